// ===== design/pra_regbank.sv
// Purpose: Paged register bank with power-up load and burn to store
// Assumes: Serial front end gives byte reads and writes on clk_i
// Notes:   Reads answer one cycle later; writes ignored while busy
`timescale 1ns/1ps
module pra_regbank (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   output logic             rvalid_o,
   input  wire logic [7:0]  cond_i,
   input  wire logic        store_programmed_i,
   output logic      [10:0] store_addr_o,
   output logic             store_rd_o,
   input  wire logic [7:0]  store_rdata_i,
   output logic             store_we_o,
   output logic      [7:0]  store_wdata_o,
   output logic             soft_rst_o,
   output logic             sync_o,
   output logic             hard_rst_o,
   output logic             pdn_o,
   output logic             busy_o,
   output logic      [7:0]  out_en_o,
   output logic      [7:0]  xtal_mhz_o,
   output logic      [7:0]  io_level_o
);
   localparam int SOFT_MAX = 42;

   pra_pkg::pra_state_t state_q;
   logic [7:0]  page_q;
   logic [7:0]  sticky_q;
   logic [2:0]  ctl_q;
   logic        hard_old_q;
   logic        start_q;
   logic        prog_q;
   logic [10:0] cnt_q;
   logic        pend_q;
   logic [10:0] pidx_q;
   logic [5:0]  soft_cnt_q;
   logic [7:0]  spec_q;
   logic        use_mem_q;
   logic [7:0]  mem_rq;
   logic [7:0]  mem [pra_pkg::MEM_WORDS];
   logic [2:0]  slot;
   logic        slot_ok;
   logic [10:0] host_idx;
   logic        host_wr;
   logic        pg0;
   logic        w_en;
   logic [10:0] w_idx;
   logic [7:0]  w_data;
   logic [10:0] r_idx;
   logic        hard_rise;
   always_comb begin
      slot    = 3'd0;
      slot_ok = 1'b1;
      unique case (page_q)
         8'h00:   slot = 3'd0;
         8'h01:   slot = 3'd1;
         8'h02:   slot = 3'd2;
         8'h03:   slot = 3'd3;
         8'h09:   slot = 3'd4;
         default: slot_ok = 1'b0;
      endcase
   end

   assign host_idx  = {slot, addr_i};
   assign host_wr   = wr_i && (state_q == pra_pkg::PRA_IDLE);
   assign pg0       = (page_q == 8'h00);
   assign busy_o    = (state_q != pra_pkg::PRA_IDLE);
   assign hard_rise = ctl_q[pra_pkg::BIT_HARD] && !hard_old_q;

   function automatic logic [7:0] def_byte(input logic [10:0] idx);
      case (idx)
         pra_pkg::IDX_OUT_EN:   return pra_pkg::DEF_OUT_EN;
         pra_pkg::IDX_XTAL:     return pra_pkg::DEF_XTAL_MHZ;
         pra_pkg::IDX_IO_LEVEL: return pra_pkg::DEF_IO_LEVEL;
         default:               return 8'h00;
      endcase
   endfunction
   always_comb begin
      w_en   = 1'b0;
      w_idx  = host_idx;
      w_data = wdata_i;
      if (state_q == pra_pkg::PRA_LOAD) begin
         w_en   = pend_q;
         w_idx  = pidx_q;
         w_data = prog_q ? store_rdata_i : def_byte(pidx_q);
      end else if (host_wr && slot_ok && addr_i != pra_pkg::ADDR_PAGE) begin
         w_en = 1'b1;
      end
   end

   assign r_idx = (state_q == pra_pkg::PRA_BURN) ? cnt_q : host_idx;
   always_ff @(posedge clk_i) begin
      if (w_en) begin
         mem[w_idx] <= w_data;
      end
      mem_rq <= mem[r_idx];
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_en_o   <= pra_pkg::DEF_OUT_EN;
         xtal_mhz_o <= pra_pkg::DEF_XTAL_MHZ;
         io_level_o <= pra_pkg::DEF_IO_LEVEL;
      end else if (w_en) begin
         case (w_idx)
            pra_pkg::IDX_OUT_EN:   out_en_o   <= w_data;
            pra_pkg::IDX_XTAL:     xtal_mhz_o <= w_data;
            pra_pkg::IDX_IO_LEVEL: io_level_o <= w_data;
            default:               ;
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_q <= pra_pkg::PAGE_RST;
      end else if (hard_rise) begin
         page_q <= pra_pkg::PAGE_RST;
      end else if (host_wr && addr_i == pra_pkg::ADDR_PAGE) begin
         page_q <= wdata_i;
      end
   end

   // Sticky flags, set wins over clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sticky_q <= 8'h00;
      end else if (host_wr && pg0 && addr_i == pra_pkg::ADDR_STICKY) begin
         sticky_q <= (sticky_q & wdata_i) | (cond_i & pra_pkg::FLAG_MASK);
      end else begin
         sticky_q <= sticky_q | (cond_i & pra_pkg::FLAG_MASK);
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q      <= 3'b000;
         hard_old_q <= 1'b0;
      end else begin
         hard_old_q <= ctl_q[pra_pkg::BIT_HARD];
         if (host_wr && pg0 && addr_i == pra_pkg::ADDR_CTL) begin
            ctl_q <= wdata_i[2:0];
         end else begin
            ctl_q[pra_pkg::BIT_SYNC] <= 1'b0;
         end
      end
   end

   assign sync_o     = ctl_q[pra_pkg::BIT_SYNC];
   assign pdn_o      = ctl_q[pra_pkg::BIT_PDN];
   assign hard_rst_o = ctl_q[pra_pkg::BIT_HARD];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_rst_o <= 1'b0;
         soft_cnt_q <= 6'd0;
      end else if (host_wr && pg0 && addr_i == pra_pkg::ADDR_SOFT && wdata_i[0]) begin
         soft_rst_o <= 1'b1;
         soft_cnt_q <= 6'(pra_pkg::SOFT_CYC);
      end else if (soft_cnt_q > 6'd1) begin
         soft_cnt_q <= soft_cnt_q - 6'd1;
      end else begin
         soft_rst_o <= 1'b0;
         soft_cnt_q <= 6'd0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= pra_pkg::PRA_LOAD;
         start_q <= 1'b1;
         prog_q  <= 1'b0;
         cnt_q   <= 11'd0;
         pend_q  <= 1'b0;
         pidx_q  <= 11'd0;
      end else if (hard_rise) begin
         state_q <= pra_pkg::PRA_LOAD;
         start_q <= 1'b1;
         cnt_q   <= 11'd0;
         pend_q  <= 1'b0;
      end else begin
         pidx_q <= cnt_q;
         unique case (state_q)
            pra_pkg::PRA_IDLE: begin
               pend_q <= 1'b0;
               cnt_q  <= 11'd0;
               if (host_wr && pg0 && addr_i == pra_pkg::ADDR_BURN &&
                   wdata_i == pra_pkg::BURN_KEY) begin
                  state_q <= pra_pkg::PRA_BURN;
               end
            end
            pra_pkg::PRA_LOAD, pra_pkg::PRA_BURN: begin
               if (start_q) begin
                  prog_q  <= store_programmed_i;
                  start_q <= 1'b0;
               end else if (pend_q && pidx_q == pra_pkg::IDX_LAST) begin
                  state_q <= pra_pkg::PRA_IDLE;
                  pend_q  <= 1'b0;
               end else begin
                  pend_q <= (cnt_q <= pra_pkg::IDX_LAST);
                  cnt_q  <= cnt_q + 11'd1;
               end
            end
            default: state_q <= pra_pkg::PRA_IDLE;
         endcase
      end
   end
   assign store_rd_o    = (state_q == pra_pkg::PRA_LOAD) && !start_q && prog_q &&
                          (cnt_q <= pra_pkg::IDX_LAST);
   assign store_addr_o  = (state_q == pra_pkg::PRA_BURN) ? pidx_q : cnt_q;
   assign store_we_o    = (state_q == pra_pkg::PRA_BURN) && pend_q;
   assign store_wdata_o = mem_rq;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_o  <= 1'b0;
         spec_q    <= 8'h00;
         use_mem_q <= 1'b0;
      end else begin
         rvalid_o  <= rd_i;
         use_mem_q <= 1'b0;
         spec_q    <= 8'h00;
         if (addr_i == pra_pkg::ADDR_READY) begin
            spec_q <= busy_o ? 8'h00 : pra_pkg::READY_VAL;
         end else if (addr_i == pra_pkg::ADDR_PAGE) begin
            spec_q <= page_q;
         end else if (busy_o || !slot_ok) begin
            spec_q <= 8'h00;
         end else if (pg0 && addr_i == pra_pkg::ADDR_STATUS) begin
            spec_q <= cond_i & pra_pkg::FLAG_MASK;
         end else if (pg0 && addr_i == pra_pkg::ADDR_STICKY) begin
            spec_q <= sticky_q;
         end else if (pg0 && addr_i == pra_pkg::ADDR_SOFT) begin
            spec_q <= {7'd0, soft_rst_o};
         end else if (pg0 && addr_i == pra_pkg::ADDR_CTL) begin
            spec_q <= {5'd0, ctl_q};
         end else if (pg0 && addr_i == pra_pkg::ADDR_BURN) begin
            spec_q <= {7'd0, (state_q == pra_pkg::PRA_BURN)};
         end else begin
            use_mem_q <= 1'b1;
         end
      end
   end

   assign rdata_o = use_mem_q ? mem_rq : spec_q;

   AST_PAGE_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      host_wr && addr_i == pra_pkg::ADDR_PAGE && !hard_rise |=> page_q == $past(wdata_i))
      else $error("page select not taken");
   AST_PAGE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(wr_i && addr_i == pra_pkg::ADDR_PAGE) && !hard_rise |=> $stable(page_q))
      else $error("page changed without select write");
   AST_PAGE_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_i && addr_i == pra_pkg::ADDR_PAGE |=> rvalid_o && rdata_o == $past(page_q))
      else $error("page readback wrong");
   AST_READY_ANY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_i && addr_i == pra_pkg::ADDR_READY && !busy_o |=> rdata_o == pra_pkg::READY_VAL)
      else $error("ready status missing");
   AST_SOFT_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(soft_rst_o) |-> soft_rst_o[*8] ##[1:SOFT_MAX] !soft_rst_o)
      else $error("soft reset did not self clear");
   AST_SYNC_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_o && !wr_i |=> !sync_o)
      else $error("sync did not self clear");
   AST_STICKY_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      |(cond_i & pra_pkg::FLAG_MASK) |=> (sticky_q & $past(cond_i & pra_pkg::FLAG_MASK))
      == $past(cond_i & pra_pkg::FLAG_MASK))
      else $error("sticky flag not set");
   AST_STICKY_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(wr_i && addr_i == pra_pkg::ADDR_STICKY) |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
      else $error("sticky flag lost");
   AST_BASE_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(busy_o) && !prog_q && $past(state_q) == pra_pkg::PRA_LOAD |-> out_en_o == 8'h00)
      else $error("base part left outputs enabled");
   AST_BASE_DEF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(busy_o) && !prog_q && $past(state_q) == pra_pkg::PRA_LOAD
      |-> xtal_mhz_o == pra_pkg::DEF_XTAL_MHZ && io_level_o == pra_pkg::DEF_IO_LEVEL)
      else $error("base defaults wrong");
   AST_BURN_WE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      store_we_o |-> state_q == pra_pkg::PRA_BURN)
      else $error("store written outside burn");
   AST_RD_ANSWER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_i |=> rvalid_o)
      else $error("read not answered");

   COV_PAGE_SWITCH: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      host_wr && addr_i == pra_pkg::ADDR_PAGE && wdata_i == 8'h04);
   COV_BURN: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(state_q == pra_pkg::PRA_BURN));
   COV_PROG_LOAD: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(busy_o) && prog_q);
   COV_STICKY_CLR: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(sticky_q[3]));
endmodule

// ===== pkg/pra_pkg.sv
// Purpose: Constants of the paged configuration register bank
// Assumes: 40 MHz clock, byte-wide register access
// Notes:   Pages 0-3 and 9 are stored, others read as zero except page select and ready
package pra_pkg;
   localparam logic [7:0]  ADDR_PAGE     = 8'h01;
   localparam logic [7:0]  ADDR_READY    = 8'hfe;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
   localparam logic [7:0]  ADDR_STICKY   = 8'h11;
   localparam logic [7:0]  ADDR_SOFT     = 8'h1c;
   localparam logic [7:0]  ADDR_CTL      = 8'h1e;
   localparam logic [7:0]  ADDR_BURN     = 8'hf3;
   localparam logic [7:0]  BURN_KEY      = 8'hc7;
   localparam logic [7:0]  READY_VAL     = 8'h0f;
   localparam logic [7:0]  FLAG_MASK     = 8'h2f;
   localparam logic [7:0]  PAGE_RST      = 8'h00;
   localparam int          BIT_PDN       = 0;
   localparam int          BIT_HARD      = 1;
   localparam int          BIT_SYNC      = 2;
   localparam logic [10:0] IDX_OUT_EN    = 11'h102;
   localparam logic [10:0] IDX_XTAL      = 11'h410;
   localparam logic [10:0] IDX_IO_LEVEL  = 11'h411;
   localparam logic [7:0]  DEF_OUT_EN    = 8'h00;
   localparam logic [7:0]  DEF_XTAL_MHZ  = 8'h30;
   localparam logic [7:0]  DEF_IO_LEVEL  = 8'h01;
   localparam int          MEM_WORDS     = 1280;
   localparam logic [10:0] IDX_LAST      = 11'h4ff;
   localparam int          SOFT_NS       = 1000;
   localparam int          CLK_NS        = 25;
   localparam int          SOFT_CYC      = (SOFT_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      PRA_IDLE = 2'b00,
      PRA_LOAD = 2'b01,
      PRA_BURN = 2'b10
   } pra_state_t;
endpackage

// ===== sim/pra_store_model.sv
// Purpose: Behavioural nonvolatile store beside the register bank
// Assumes: Word data is wanted the cycle after a read strobe
// Notes:   Data bus shows a changing pattern when not read
`timescale 1ns/1ps
module pra_store_model (
   input  wire logic        clk_i,
   input  wire logic [10:0] store_addr_i,
   input  wire logic        store_rd_i,
   input  wire logic        store_we_i,
   input  wire logic [7:0]  store_wdata_i,
   output logic      [7:0]  store_rdata_o
);
   logic [7:0] mem [pra_pkg::MEM_WORDS];

   initial begin
      for (int i = 0; i < pra_pkg::MEM_WORDS; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
      store_rdata_o = 8'h00;
   end

   // Word answer one cycle on, otherwise toggling
   always @(posedge clk_i) begin
      if (store_rd_i) begin
         store_rdata_o <= mem[store_addr_i];
      end else begin
         store_rdata_o <= ~store_rdata_o;
      end
   end

   // Burn words captured
   always @(posedge clk_i) begin
      if (store_we_i) begin
         mem[store_addr_i] <= store_wdata_i;
      end
   end
endmodule

// ===== sim/paged_register_access_tb_top.sv
// Purpose: Self-checking bench of the paged register bank
// Assumes: Inputs driven 2 ns after the rising edge
// Notes:   Base variant first, then burn and programmed reload
`timescale 1ns/1ps
module paged_register_access_tb_top;
   logic        clk_i;
   logic        rst_n_i;
   logic        wr_i;
   logic        rd_i;
   logic [7:0]  addr_i;
   logic [7:0]  wdata_i;
   logic [7:0]  rdata_o;
   logic        rvalid_o;
   logic [7:0]  cond_i;
   logic        store_programmed_i;
   logic [10:0] store_addr_o;
   logic        store_rd_o;
   logic [7:0]  store_rdata_i;
   logic        store_we_o;
   logic [7:0]  store_wdata_o;
   logic        soft_rst_o;
   logic        sync_o;
   logic        hard_rst_o;
   logic        pdn_o;
   logic        busy_o;
   logic [7:0]  out_en_o;
   logic [7:0]  xtal_mhz_o;
   logic [7:0]  io_level_o;
   int          error_cnt;
   int          samples_checked;
   int          we_cnt;
   int          rd_cnt;
   logic [7:0]  v;
   logic [7:0]  pg [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h09, 8'h04, 8'h05};

   pra_regbank DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .cond_i(cond_i), .store_programmed_i(store_programmed_i),
      .store_addr_o(store_addr_o), .store_rd_o(store_rd_o), .store_rdata_i(store_rdata_i),
      .store_we_o(store_we_o), .store_wdata_o(store_wdata_o), .soft_rst_o(soft_rst_o),
      .sync_o(sync_o), .hard_rst_o(hard_rst_o), .pdn_o(pdn_o), .busy_o(busy_o),
      .out_en_o(out_en_o), .xtal_mhz_o(xtal_mhz_o), .io_level_o(io_level_o));

   pra_store_model st (.clk_i(clk_i), .store_addr_i(store_addr_o), .store_rd_i(store_rd_o),
      .store_we_i(store_we_o), .store_wdata_i(store_wdata_o), .store_rdata_o(store_rdata_i));

   initial clk_i = 1'b0;
   always #12.5 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      if (store_we_o === 1'b1) we_cnt++;
      if (store_rd_o === 1'b1) rd_cnt++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #2 wr_i = 1'b1; addr_i = a; wdata_i = d;
      @(posedge clk_i);
      #2 wr_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #2 rd_i = 1'b1; addr_i = a;
      @(posedge clk_i);
      #2 rd_i = 1'b0;
      check(rvalid_o, 1'b1);
      d = rdata_o;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_o !== 1'b0 && n < 2000) begin
         @(posedge clk_i);
         #2 n++;
      end
      check(n < 2000, 1'b1);
   endtask

   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #2 rst_n_i = 1'b1; we_cnt = 0; rd_cnt = 0;
   endtask

   initial begin
      rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
      cond_i = 8'h00; store_programmed_i = 1'b0; error_cnt = 0; samples_checked = 0;
      we_cnt = 0; rd_cnt = 0;
      do_reset();
      rd_chk(pra_pkg::ADDR_READY, 8'h00);
      wait_idle();
      check(rd_cnt, 0);
      check(out_en_o, 8'h00);
      check(xtal_mhz_o, 8'h30);
      check(io_level_o, 8'h01);
      rd_chk(pra_pkg::ADDR_PAGE, 8'h00);
      rd_chk(pra_pkg::ADDR_READY, pra_pkg::READY_VAL);
      $display("test base_defaults done");
      for (int i = 0; i < 7; i++) begin
         wr(pra_pkg::ADDR_PAGE, pg[i]);
         if (i < 5) begin
            wr(8'h50, 8'h80 | pg[i]);
         end
      end
      for (int i = 0; i < 7; i++) begin
         wr(pra_pkg::ADDR_PAGE, pg[i]);
         rd_chk(pra_pkg::ADDR_PAGE, pg[i]);
         rd_chk(8'h50, (i < 5) ? (8'h80 | pg[i]) : 8'h00);
         rd_chk(pra_pkg::ADDR_READY, pra_pkg::READY_VAL);
      end
      wr(pra_pkg::ADDR_PAGE, 8'h01);
      wr(8'h02, 8'ha5);
      check(out_en_o, 8'ha5);
      rd_chk(8'h02, 8'ha5);
      wr(pra_pkg::ADDR_PAGE, 8'h09);
      wr(8'h10, 8'h19);
      check(xtal_mhz_o, 8'h19);
      rd_chk(8'h11, 8'h01);
      $display("test paging done");
      wr(pra_pkg::ADDR_PAGE, 8'h00);
      cond_i = 8'hff;
      repeat (2) @(posedge clk_i);
      rd_chk(pra_pkg::ADDR_STATUS, pra_pkg::FLAG_MASK);
      cond_i = 8'h00;
      rd_chk(pra_pkg::ADDR_STATUS, 8'h00);
      rd(pra_pkg::ADDR_STICKY, v);
      check(v, pra_pkg::FLAG_MASK);
      wr(pra_pkg::ADDR_STICKY, v & 8'hfe);
      rd_chk(pra_pkg::ADDR_STICKY, 8'h2e);
      wr(pra_pkg::ADDR_STICKY, 8'h00);
      rd_chk(pra_pkg::ADDR_STICKY, 8'h00);
      $display("test sticky done");
      wr(pra_pkg::ADDR_SOFT, 8'h01);
      check(soft_rst_o, 1'b1);
      begin
         int n;
         n = 0;
         while (soft_rst_o === 1'b1 && n < 100) begin
            @(posedge clk_i);
            #2 n++;
         end
         check(n, pra_pkg::SOFT_CYC);
      end
      rd_chk(pra_pkg::ADDR_SOFT, 8'h00);
      wr(pra_pkg::ADDR_CTL, 8'h04);
      check(sync_o, 1'b1);
      rd_chk(pra_pkg::ADDR_CTL, 8'h00);
      wr(pra_pkg::ADDR_CTL, 8'h01);
      check(pdn_o, 1'b1);
      wr(pra_pkg::ADDR_CTL, 8'h00);
      check(pdn_o, 1'b0);
      $display("test self_clear done");
      we_cnt = 0;
      wr(pra_pkg::ADDR_BURN, pra_pkg::BURN_KEY);
      check(busy_o, 1'b1);
      wr(pra_pkg::ADDR_PAGE, 8'h02);
      wait_idle();
      check(we_cnt, pra_pkg::MEM_WORDS);
      check(st.mem[11'h102], 8'ha5);
      check(st.mem[11'h410], 8'h19);
      rd_chk(pra_pkg::ADDR_PAGE, 8'h00);
      $display("test burn done");
      store_programmed_i = 1'b1;
      do_reset();
      wait_idle();
      check(rd_cnt, pra_pkg::MEM_WORDS);
      check(out_en_o, 8'ha5);
      check(xtal_mhz_o, 8'h19);
      rd_chk(pra_pkg::ADDR_PAGE, 8'h00);
      wr(pra_pkg::ADDR_PAGE, 8'h02);
      rd_chk(8'h50, 8'h82);
      $display("test programmed_load done");
      wr(pra_pkg::ADDR_PAGE, 8'h01);
      wr(8'h02, 8'h3c);
      check(out_en_o, 8'h3c);
      wr(pra_pkg::ADDR_PAGE, 8'h00);
      rd_cnt = 0;
      wr(pra_pkg::ADDR_CTL, 8'h02);
      check(hard_rst_o, 1'b1);
      @(posedge clk_i);
      #2 check(busy_o, 1'b1);
      wait_idle();
      check(rd_cnt, pra_pkg::MEM_WORDS);
      check(out_en_o, 8'ha5);
      check(hard_rst_o, 1'b1);
      rd_chk(pra_pkg::ADDR_PAGE, 8'h00);
      wr(pra_pkg::ADDR_CTL, 8'h00);
      check(hard_rst_o, 1'b0);
      $display("test hard_reset done");
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end
endmodule
